// ===== design/mgac_gate_arm_ctrl.sv
// Gate, arm, delay and inhibit sequencing for one measurement block
`timescale 1ns/1ps
`default_nettype none
`include "mgac_params.svh"

// Function
// - Time-stamp event limit up to 32000
// - Phase and duty limit up to 16000
// - Histogram event limit up to 99999999
// - Force block end 320 s after arming
// - Time gate lasts 1 us to 10 s
// - Time gate ends early at mode maximum
// - External gate measures at chosen level
// - External gate ends at maximum count/time
// - Intervals 71 ns to 4 ms; histogram fastest
// - External gate disables arming settings
// - Arm automatically or from external input
// - External arm on chosen edge
// - Arm delay: none, time or events
// - Time delay 1 us to 1 s
// - Event delay from decade steps, max 30000
// - Delay events on measuring channel, A for TI
// - Inhibit suspends measurement at active level
// - Inhibit honoured only first 320 s
// - Event, time and external gate types
module mgac_gate_arm_ctrl import mgac_pkg::*; #(
	parameter logic [28:0] MAX_SAMPLE_US =
		29'(`MGAC_MAX_SAMPLE_S * `MGAC_US_PER_S)
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire mgac_cfg_t cfg_i,
	input wire logic start_i,
	input wire logic external_arm_gate_input_i,
	input wire logic inhibit_i,
	input wire logic channel_a_input_i,
	input wire logic channel_b_input_i,
	output mgac_stat_t stat_o,
	output logic sample_tick_o,
	output logic block_done_o
);

	// ----------------------------------------
	// Constants
	// ----------------------------------------
	localparam logic [6:0] US_CYC = 7'(`MGAC_US_CYC);
	localparam logic [3:0] MIN_CYC = 4'(`MGAC_MIN_IVL_CYC);
	localparam logic [23:0] GATE_MAX_US =
		24'(`MGAC_GATE_MAX_S * `MGAC_US_PER_S);
	localparam logic [19:0] DLY_MAX_US =
		20'(`MGAC_DLY_MAX_S * `MGAC_US_PER_S);

	typedef enum logic [2:0] {
		ST_IDLE, ST_WAIT_ARM, ST_DLY_TIME, ST_DLY_EVT, ST_MEASURE
	} mgac_state_t;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	mgac_cfg_t cfg; // Settings held for the block
	mgac_state_t state;
	mgac_state_t next_state;
	logic [3:0] pins; // Filtered pin levels
	logic [3:0] pins_prev; // For edge detection
	logic [2:0] settle; // Cycles since reset, saturating
	logic edge_ok; // Synchroniser flushed
	logic ext_s;
	logic inh_s;
	logic a_rise;
	logic b_rise;
	logic ext_rise;
	logic ext_fall;
	logic arm_edge;
	logic evt; // Event on the counted channel
	logic [6:0] us_pre; // Microsecond prescaler
	logic us_tick;
	logic [28:0] since_arm; // Microseconds since arming
	logic max_time;
	logic [23:0] tmr_us; // Delay or gate timer
	logic [14:0] dly_cnt; // Skipped events
	logic [26:0] evt_cnt;
	logic [26:0] mode_max;
	logic [26:0] evt_lim;
	logic [23:0] gate_lim;
	logic [19:0] dly_lim;
	logic [14:0] dly_evts;
	logic inh_act;
	logic ext_ok;
	logic gate_open;
	logic armed;
	logic end_cnt;
	logic end_gate;
	logic [3:0] ivl_cyc; // Fast interval counter
	logic [11:0] ivl_us; // Slow interval counter
	logic [3:0] ivl_eff;
	logic ivl_hit;
	mgac_end_t end_cause;
	logic cfg_err;

	// ----------------------------------------
	// Lookup functions
	// ----------------------------------------
	// Event delay: digit 1..9 times a decade
	function automatic logic [14:0] dly_table(input logic [5:0] code);
		logic [2:0] dec;
		logic [14:0] val;
		dec = 3'(code / 6'h09);
		val = 15'(code % 6'h09) + 15'h0001;
		for (int i = 0; i < 4; i++) begin
			if (i < int'(dec)) begin
				val = 15'(val * 15'h000A);
			end
		end
		if (code >= `MGAC_DLY_CODES) begin
			val = `MGAC_DLY_EVT_MAX;
		end
		return val;
	endfunction : dly_table

	// Slow intervals in us: 1-2-4 steps per decade
	function automatic logic [11:0] ivl_table(input logic [3:0] code);
		logic [3:0] k;
		logic [11:0] val;
		k = code - 4'h1;
		case (k % 4'h3)
			4'h0: val = 12'h001;
			4'h1: val = 12'h002;
			default: val = 12'h004;
		endcase
		for (int i = 0; i < 3; i++) begin
			if (i < int'(k / 4'h3)) begin
				val = 12'(val * 12'h00A);
			end
		end
		return val;
	endfunction : ivl_table

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	mgac_sync #(
		.W(4)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.pin_i({external_arm_gate_input_i, inhibit_i,
			channel_b_input_i, channel_a_input_i}),
		.level_o(pins)
	);

	// Previous levels for edge detection; edges stay masked until the
	// chain has flushed, so a pin idling high gives no false edge
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pins_prev <= 4'h0;
			settle <= 3'h0;
		end else begin
			pins_prev <= pins;
			if (settle != `MGAC_SETTLE_CYC) begin
				settle <= settle + 3'h1;
			end
		end
	end

	assign ext_s = pins[3];
	assign inh_s = pins[2];
	assign edge_ok = (settle == `MGAC_SETTLE_CYC);
	assign a_rise = edge_ok & pins[0] & ~pins_prev[0];
	assign b_rise = edge_ok & pins[1] & ~pins_prev[1];
	assign ext_rise = edge_ok & pins[3] & ~pins_prev[3];
	assign ext_fall = edge_ok & ~pins[3] & pins_prev[3];
	assign arm_edge = cfg.arm_fall ? ext_fall : ext_rise;
	assign evt = (cfg.func == FN_TINT || !cfg.chan_b) ? a_rise : b_rise;

	// ----------------------------------------
	// Effective limits
	// ----------------------------------------
	// Clamp settings so a bad value cannot stall
	always_comb begin
		if (cfg.samp == SAMP_HIST) begin
			mode_max = `MGAC_HH_MAX_EVT;
		end else if (cfg.func == FN_PHASE || cfg.func == FN_DUTY) begin
			mode_max = `MGAC_TS_MAX_EVT_PH;
		end else begin
			mode_max = `MGAC_TS_MAX_EVT;
		end
		// Other gates still stop at the mode ceiling
		evt_lim = mode_max;
		if (cfg.gate == GATE_EVENT && cfg.evt_limit < mode_max) begin
			evt_lim = (cfg.evt_limit == 27'h0) ? 27'h1 : cfg.evt_limit;
		end
		gate_lim = cfg.gate_us;
		if (cfg.gate_us < `MGAC_GATE_MIN_US) begin
			gate_lim = `MGAC_GATE_MIN_US;
		end else if (cfg.gate_us > GATE_MAX_US) begin
			gate_lim = GATE_MAX_US;
		end
		dly_lim = cfg.dly_us;
		if (cfg.dly_us < `MGAC_DLY_MIN_US) begin
			dly_lim = `MGAC_DLY_MIN_US;
		end else if (cfg.dly_us > DLY_MAX_US) begin
			dly_lim = DLY_MAX_US;
		end
	end

	assign dly_evts = dly_table(cfg.dly_code);

	// Flag settings that were clamped or unavailable
	always_comb begin
		cfg_err = 1'b0;
		if (cfg.gate == GATE_EVENT &&
			(cfg.evt_limit == 27'h0 || cfg.evt_limit > mode_max)) begin
			cfg_err = 1'b1;
		end
		if (cfg.gate == GATE_TIME && gate_lim != cfg.gate_us) begin
			cfg_err = 1'b1;
		end
		if (cfg.gate != GATE_EXT && cfg.arm_ext) begin
			if (cfg.dly == DLY_TIME && dly_lim != cfg.dly_us) begin
				cfg_err = 1'b1;
			end
			if (cfg.dly == DLY_EVENT && cfg.dly_code >= `MGAC_DLY_CODES) begin
				cfg_err = 1'b1;
			end
		end
		// Phase and duty do not exist in histogram mode
		if (cfg.samp == SAMP_HIST &&
			(cfg.func == FN_PHASE || cfg.func == FN_DUTY)) begin
			cfg_err = 1'b1;
		end
		if (cfg.ivl_code >= `MGAC_IVL_CODES) begin
			cfg_err = 1'b1;
		end
	end

	// ----------------------------------------
	// Configuration capture
	// ----------------------------------------
	// Held for the block so edits do not upset it
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cfg <= '0;
		end else if (start_i && state == ST_IDLE) begin
			cfg <= cfg_i;
		end
	end

	// ----------------------------------------
	// Microsecond base and arm timer
	// ----------------------------------------
	// Free-running prescaler
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			us_pre <= 7'h00;
		end else if (us_pre == US_CYC - 7'h01) begin
			us_pre <= 7'h00;
		end else begin
			us_pre <= us_pre + 7'h01;
		end
	end

	assign us_tick = (us_pre == US_CYC - 7'h01);
	assign armed = (state == ST_DLY_TIME || state == ST_DLY_EVT ||
		state == ST_MEASURE);

	// Elapsed time since arming, saturating
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			since_arm <= 29'h0000_0000;
		end else if (!armed) begin
			since_arm <= 29'h0000_0000;
		end else if (us_tick && !max_time) begin
			since_arm <= since_arm + 29'h0000_0001;
		end
	end

	assign max_time = (since_arm >= MAX_SAMPLE_US);

	// ----------------------------------------
	// Gating terms
	// ----------------------------------------
	// inhibit at active level
	assign inh_act = (cfg.inh != INH_OFF) && !max_time &&
		((cfg.inh == INH_POS) ? inh_s : !inh_s);
	assign ext_ok = (cfg.gate != GATE_EXT) ||
		(cfg.gate_neg ? !ext_s : ext_s);
	assign gate_open = (state == ST_MEASURE) && !inh_act && ext_ok;

	assign end_cnt = (evt_cnt >= evt_lim);
	assign end_gate = (cfg.gate == GATE_TIME) && (tmr_us >= gate_lim);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// three gate types
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (start_i) begin
					if (cfg_i.gate == GATE_EXT || !cfg_i.arm_ext) begin
						next_state = ST_MEASURE;
					end else begin
						next_state = ST_WAIT_ARM;
					end
				end
			end
			ST_WAIT_ARM: begin
				if (arm_edge) begin
					case (cfg.dly)
						DLY_TIME: next_state = ST_DLY_TIME;
						DLY_EVENT: next_state = ST_DLY_EVT;
						default: next_state = ST_MEASURE;
					endcase
				end
			end
			ST_DLY_TIME: begin
				if (max_time) begin
					next_state = ST_IDLE;
				end else if (tmr_us >= 24'(dly_lim)) begin
					next_state = ST_MEASURE;
				end
			end
			ST_DLY_EVT: begin
				if (max_time) begin
					next_state = ST_IDLE;
				end else if (dly_cnt >= dly_evts) begin
					next_state = ST_MEASURE;
				end
			end
			ST_MEASURE: begin
				if (end_cnt || max_time || end_gate) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Timer restarts on every state change
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tmr_us <= 24'h00_0000;
		end else if (next_state != state) begin
			tmr_us <= 24'h00_0000;
		end else if (us_tick && tmr_us != 24'hFF_FFFF) begin
			tmr_us <= tmr_us + 24'h00_0001;
		end
	end

	// Delay event counter
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			dly_cnt <= 15'h0000;
		end else if (state != ST_DLY_EVT) begin
			dly_cnt <= 15'h0000;
		end else if (evt) begin
			dly_cnt <= dly_cnt + 15'h0001;
		end
	end

	// Measured events, counted only with gate open
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			evt_cnt <= 27'h000_0000;
		end else if (start_i && state == ST_IDLE) begin
			evt_cnt <= 27'h000_0000;
		end else if (gate_open && evt && !end_cnt) begin
			evt_cnt <= evt_cnt + 27'h000_0001;
		end
	end

	// End cause and completion pulse
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			end_cause <= END_NONE;
			block_done_o <= 1'b0;
		end else begin
			block_done_o <= 1'b0;
			if (start_i && state == ST_IDLE) begin
				end_cause <= END_NONE;
			end else if (armed && next_state == ST_IDLE) begin
				block_done_o <= 1'b1;
				// Count first, then time limit, then gate
				if (state == ST_MEASURE && end_cnt) begin
					end_cause <= END_COUNT;
				end else if (max_time) begin
					end_cause <= END_MAXTIME;
				end else begin
					end_cause <= END_GATE;
				end
			end
		end
	end

	// ----------------------------------------
	// Sampling interval
	// ----------------------------------------
	// histogram forced to fastest
	assign ivl_eff = (cfg.samp == SAMP_HIST ||
		cfg.ivl_code >= `MGAC_IVL_CODES) ? 4'h0 : cfg.ivl_code;
	assign ivl_hit = (ivl_eff == 4'h0) ? (ivl_cyc >= MIN_CYC - 4'h1) :
		(us_tick && ivl_us >= ivl_table(ivl_eff) - 12'h001);

	// Interval counters; restart while the gate is shut
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ivl_cyc <= 4'h0;
			ivl_us <= 12'h000;
			sample_tick_o <= 1'b0;
		end else if (!gate_open) begin
			ivl_cyc <= 4'h0;
			ivl_us <= 12'h000;
			sample_tick_o <= 1'b0;
		end else begin
			sample_tick_o <= ivl_hit;
			ivl_cyc <= ivl_hit ? 4'h0 : ivl_cyc + 4'h1;
			if (ivl_hit) begin
				ivl_us <= 12'h000;
			end else if (us_tick) begin
				ivl_us <= ivl_us + 12'h001;
			end
		end
	end

	// ----------------------------------------
	// Status outputs
	// ----------------------------------------
	// Registered copy of block state
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			stat_o <= '0;
		end else begin
			stat_o.active <= (state != ST_IDLE);
			stat_o.armed <= armed;
			stat_o.gate_open <= gate_open;
			stat_o.end_cause <= end_cause;
			stat_o.evt_count <= evt_cnt;
			stat_o.cfg_error <= cfg_err;
		end
	end

endmodule : mgac_gate_arm_ctrl
`default_nettype wire

// ===== design/mgac_params.svh
// Timing figures and limits of the gate and arm controller
`ifndef MGAC_PARAMS_SVH
`define MGAC_PARAMS_SVH

// ----------------------------------------
// Clock and time units
// ----------------------------------------
`define MGAC_CLK_NS 32'h0000_000A
`define MGAC_US_NS 32'h0000_03E8
`define MGAC_US_PER_S 32'h000F_4240
// Cycles in one microsecond, rounded down
`define MGAC_US_CYC (`MGAC_US_NS / `MGAC_CLK_NS)
// Fastest sampling interval, 71 ns
`define MGAC_MIN_IVL_NS 32'h0000_0047
// Least spacing, so rounded up
`define MGAC_MIN_IVL_CYC \
	((`MGAC_MIN_IVL_NS + `MGAC_CLK_NS - 32'h1) / `MGAC_CLK_NS)
// Cycles after reset until edge detection sees true pin levels
`define MGAC_SETTLE_CYC 3'h5

// ----------------------------------------
// Block limits
// ----------------------------------------
// Maximum sampling time, 320 s after arming
`define MGAC_MAX_SAMPLE_S 32'h0000_0140
`define MGAC_TS_MAX_EVT 27'h000_7D00
`define MGAC_TS_MAX_EVT_PH 27'h000_3E80
`define MGAC_HH_MAX_EVT 27'h5F5_E0FF
// Gate time 1 us to 10 s
`define MGAC_GATE_MIN_US 24'h00_0001
`define MGAC_GATE_MAX_S 32'h0000_000A
// Arming delay 1 us to 1 s
`define MGAC_DLY_MIN_US 20'h0_0001
`define MGAC_DLY_MAX_S 32'h0000_0001
// Event delay table size and ceiling
`define MGAC_DLY_CODES 6'h27
`define MGAC_DLY_EVT_MAX 15'h7530
// Interval codes: MIN plus twelve steps
`define MGAC_IVL_CODES 4'hD

`endif

// ===== design/mgac_pkg.sv
// Types shared by the gate and arm controller
package mgac_pkg;

	// ----------------------------------------
	// Mode enumerations
	// ----------------------------------------
	typedef enum logic [1:0] {GATE_EVENT, GATE_TIME, GATE_EXT} mgac_gate_t;
	typedef enum logic {SAMP_TSTAMP, SAMP_HIST} mgac_samp_t;
	typedef enum logic [2:0] {
		FN_PERIOD, FN_TINT, FN_PWIDTH, FN_PHASE, FN_DUTY
	} mgac_func_t;
	typedef enum logic [1:0] {DLY_OFF, DLY_TIME, DLY_EVENT} mgac_dly_t;
	typedef enum logic [1:0] {INH_OFF, INH_POS, INH_NEG} mgac_inh_t;
	typedef enum logic [1:0] {
		END_NONE, END_COUNT, END_GATE, END_MAXTIME
	} mgac_end_t;

	// ----------------------------------------
	// Configuration, caught at block start
	// ----------------------------------------
	typedef struct packed {
		mgac_gate_t gate;
		mgac_samp_t samp;
		mgac_func_t func;
		logic chan_b;
		logic [26:0] evt_limit;
		logic [23:0] gate_us;
		logic gate_neg;
		logic arm_ext;
		logic arm_fall;
		mgac_dly_t dly;
		logic [19:0] dly_us;
		logic [5:0] dly_code;
		mgac_inh_t inh;
		logic [3:0] ivl_code;
	} mgac_cfg_t;

	// ----------------------------------------
	// Status of the running block
	// ----------------------------------------
	typedef struct packed {
		logic active;
		logic armed;
		logic gate_open;
		mgac_end_t end_cause;
		logic [26:0] evt_count;
		logic cfg_error;
	} mgac_stat_t;

endpackage : mgac_pkg

// ===== design/mgac_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module mgac_sync #(
	parameter int W = 4
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] level_o
);

	// Stage flops, one chain per bit
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// ----------------------------------------
	// Per-bit chain
	// ----------------------------------------
	for (genvar b = 0; b < W; b++) begin : g_bit
		// First stage feeds only the second
		always_ff @(posedge clk_sys_i) begin
			if (rst_i) begin
				s1[b] <= 1'b0;
				s2[b] <= 1'b0;
				s3[b] <= 1'b0;
				level_o[b] <= 1'b0;
			end else begin
				s1[b] <= pin_i[b];
				s2[b] <= s1[b];
				s3[b] <= s2[b];
				// Accept a change once two stages agree
				if (s2[b] == s3[b]) begin
					level_o[b] <= s3[b];
				end
			end
		end
	end

endmodule : mgac_sync
`default_nettype wire

// ===== tb/mgac_gate_arm_ctrl_properties.sv
// Port-level checks of the gate and arm controller
`timescale 1ns/1ps
`default_nettype none

module mgac_props import mgac_pkg::*; #(
	parameter logic [28:0] MAX_SAMPLE_US = 29'h1312_D000
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire mgac_stat_t stat_o,
	input wire logic sample_tick_o,
	input wire logic block_done_o
);
	// ----------------------------------------
	// Armed-time counter
	// ----------------------------------------
	// Slack covers the microsecond prescaler and pipeline
	localparam logic [35:0] LIM = 36'(MAX_SAMPLE_US) * 36'h64 + 36'hC8;
	logic [35:0] arm_cyc; // Cycles since arming
	// Restarts whenever the block is not armed
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || !stat_o.armed) begin
			arm_cyc <= 36'h0;
		end else begin
			arm_cyc <= arm_cyc + 36'h1;
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	sequence s_close;
		stat_o.active ##1 !stat_o.active;
	endsequence
	sequence s_quiet;
		!sample_tick_o [*7];
	endsequence
	property p_done_pulse; block_done_o |=> !block_done_o; endproperty
	property p_done_close; block_done_o |-> s_close; endproperty
	property p_done_cause;
		block_done_o |-> ##[0:1] stat_o.end_cause != END_NONE;
	endproperty
	property p_fell; $fell(stat_o.active) |-> $past(block_done_o); endproperty
	property p_start; start_i && !stat_o.active |-> ##2 stat_o.active; endproperty
	property p_arm; stat_o.gate_open |-> stat_o.armed && stat_o.active; endproperty
	property p_tick_gate;
		sample_tick_o |-> stat_o.gate_open || $past(stat_o.gate_open);
	endproperty
	property p_tick_space; sample_tick_o |=> s_quiet; endproperty
	property p_cnt_step;
		stat_o.active && $past(stat_o.active)
			|-> stat_o.evt_count - $past(stat_o.evt_count) <= 27'h1;
	endproperty
	property p_cnt_gate;
		stat_o.evt_count != $past(stat_o.evt_count) && $past(stat_o.active)
			|-> stat_o.gate_open || $past(stat_o.gate_open);
	endproperty
	property p_maxtime; arm_cyc <= LIM; endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("done pulse longer than one cycle");
	a_done_close: assert property (p_done_close)
		else $error("block still active after done");
	a_done_cause: assert property (p_done_cause)
		else $error("done without end cause");
	a_fell: assert property (p_fell)
		else $error("block ended without done");
	a_start: assert property (p_start)
		else $error("start from idle not taken");
	a_arm: assert property (p_arm)
		else $error("gate open while not armed");
	a_tick_gate: assert property (p_tick_gate)
		else $error("sample tick with gate shut");
	a_tick_space: assert property (p_tick_space)
		else $error("sample ticks closer than fastest interval");
	a_cnt_step: assert property (p_cnt_step)
		else $error("event count jumped");
	a_cnt_gate: assert property (p_cnt_gate)
		else $error("event counted with gate shut");
	a_maxtime: assert property (p_maxtime)
		else $error("block outlived maximum sampling time");
endmodule : mgac_props

bind mgac_gate_arm_ctrl mgac_props #(.MAX_SAMPLE_US(MAX_SAMPLE_US)) mgac_props_i (
	.clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(start_i),
	.stat_o(stat_o), .sample_tick_o(sample_tick_o), .block_done_o(block_done_o)
);
`default_nettype wire

// ===== tb/mgac_gate_arm_ctrl_test.sv
// Self-checking bench for the gate and arm controller
`timescale 1ns/1ps
`default_nettype none

module mgac_gate_arm_ctrl_test import mgac_pkg::*; ;
	// ----------------------------------------
	// Rows, signals and counters
	// ----------------------------------------
	typedef struct packed {
		mgac_func_t func;
		mgac_samp_t samp;
		logic chb; // Measure channel B
		logic [26:0] lim; // Requested limit
		logic [1:0] ev; // Trains on B, A
		logic [26:0] cnt; // Final count
		mgac_end_t fin; // End cause
		logic err; // Setting error
	} mgac_row_t;
	// Short maximum keeps a timed-out block at 5000 cycles
	localparam int MAX_US = 50;
	localparam int MAXC = MAX_US * 100;
	logic clk_sys_i, rst_i, start_i, ext_i, inh_i;
	logic ev_a, ev_b, ch_a, ch_b, sample_tick_o, block_done_o;
	mgac_cfg_t cfg_i, c;
	mgac_stat_t stat_o;
	mgac_row_t rows [10];
	int lo [3] = '{4, 100, 28}; // Edge-to-end window per delay kind
	int hi [3] = '{24, 260, 60};
	int mismatches = 0;
	int n_tests = 0;
	int cyc = 0;
	int ticks = 0;
	int dur, i, n;

	mgac_gate_arm_ctrl #(.MAX_SAMPLE_US(29'(MAX_US))) mgac_gate_arm_ctrl_i (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cfg_i(cfg_i),
		.start_i(start_i), .external_arm_gate_input_i(ext_i),
		.inhibit_i(inh_i), .channel_a_input_i(ch_a),
		.channel_b_input_i(ch_b), .stat_o(stat_o),
		.sample_tick_o(sample_tick_o), .block_done_o(block_done_o)
	);
	mgac_pin_model mgac_pin_model_i (
		.clk_sys_i(clk_sys_i), .ena_a_i(ev_a), .ena_b_i(ev_b),
		.chan_a_o(ch_a), .chan_b_o(ch_b)
	);

	// ----------------------------------------
	// Clock, tick tally and hang guard
	// ----------------------------------------
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	// Run needs about 47000 cycles
	always @(posedge clk_sys_i) begin
		cyc++;
		if (sample_tick_o === 1'b1)
			ticks++;
		if (cyc == 65000) begin
			mismatches++;
			end_sim();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t seen %0h want %0h", $time, seen, exp);
		end
	endtask : check
	// Inputs always move 1 ns after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : tick
	task automatic go(input mgac_cfg_t k);
		cfg_i = k;
		start_i = 1'b1;
		tick(1);
		start_i = 1'b0;
		ticks = 0;
	endtask : go
	// Bounded wait; leaves one cycle after done
	task automatic wait_done(input int lim);
		dur = 0;
		while (block_done_o !== 1'b1 && dur < lim) begin
			tick(1);
			dur++;
		end
		check(block_done_o, 1'b1);
		tick(1);
	endtask : wait_done
	task automatic end_sim();
		$display("Checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rows[0] = '{FN_TINT, SAMP_TSTAMP, 1'b1, 27'h000_0005, 2'h1,
			27'h000_0005, END_COUNT, 1'b0};
		rows[1] = '{FN_PERIOD, SAMP_TSTAMP, 1'b1, 27'h000_0005, 2'h1,
			27'h000_0000, END_MAXTIME, 1'b0};
		rows[2] = '{FN_PWIDTH, SAMP_TSTAMP, 1'b1, 27'h000_0003, 2'h2,
			27'h000_0003, END_COUNT, 1'b0};
		rows[3] = '{FN_PERIOD, SAMP_TSTAMP, 1'b0, 27'h000_0000, 2'h1,
			27'h000_0001, END_COUNT, 1'b1};
		rows[4] = '{FN_PERIOD, SAMP_TSTAMP, 1'b0, 27'h000_7D00, 2'h0,
			27'h000_0000, END_MAXTIME, 1'b0};
		rows[5] = '{FN_PERIOD, SAMP_TSTAMP, 1'b0, 27'h000_7D01, 2'h0,
			27'h000_0000, END_MAXTIME, 1'b1};
		rows[6] = '{FN_PHASE, SAMP_TSTAMP, 1'b0, 27'h000_3E80, 2'h0,
			27'h000_0000, END_MAXTIME, 1'b0};
		rows[7] = '{FN_DUTY, SAMP_TSTAMP, 1'b0, 27'h000_3E81, 2'h0,
			27'h000_0000, END_MAXTIME, 1'b1};
		rows[8] = '{FN_PERIOD, SAMP_HIST, 1'b0, 27'h5F5_E0FF, 2'h0,
			27'h000_0000, END_MAXTIME, 1'b0};
		rows[9] = '{FN_PERIOD, SAMP_HIST, 1'b0, 27'h5F5_E100, 2'h0,
			27'h000_0000, END_MAXTIME, 1'b1};
		{rst_i, start_i, ext_i, inh_i, ev_a, ev_b} = 6'h20;
		cfg_i = '0;
		tick(3);
		check({stat_o, block_done_o, sample_tick_o} === 35'h0, 1'b1);
		rst_i = 1'b0;
		// Limits, clamps and channel choice
		for (i = 0; i < 10; i++) begin
			c = '0;
			c.func = rows[i].func;
			c.samp = rows[i].samp;
			c.chan_b = rows[i].chb;
			c.evt_limit = rows[i].lim;
			{ev_b, ev_a} = rows[i].ev;
			tick(8);
			go(c);
			wait_done(MAXC + 300);
			check(stat_o.end_cause, rows[i].fin);
			check(stat_o.evt_count, rows[i].cnt);
			check(stat_o.cfg_error, rows[i].err);
			if (rows[i].fin == END_MAXTIME)
				check(dur > MAXC - 150 && dur < MAXC + 150, 1'b1);
		end
		// Timed gate; histogram forces fastest interval
		for (i = 0; i < 2; i++) begin
			c = '0;
			c.gate = GATE_TIME;
			c.gate_us = 24'h00_0003;
			c.samp = i ? SAMP_TSTAMP : SAMP_HIST;
			c.ivl_code = i ? 4'h1 : 4'h3;
			go(c);
			wait_done(600);
			check(stat_o.end_cause, END_GATE);
			check(dur >= 200 && dur <= 320, 1'b1);
			check(ticks >= (i ? 1 : 24) && ticks <= (i ? 3 : 40), 1'b1);
		end
		// External gate at both levels; arm settings present but ignored
		for (i = 0; i < 2; i++) begin
			c = '0;
			c.gate = GATE_EXT;
			c.gate_neg = (i == 0);
			c.arm_ext = 1'b1;
			c.dly = DLY_TIME;
			c.dly_us = 20'h0_0005;
			// Gate starts shut: pin at its inactive level
			{ext_i, ev_b, ev_a} = {c.gate_neg, 2'h1};
			tick(8);
			go(c);
			tick(30);
			check(stat_o.armed, 1'b1);
			check(stat_o.gate_open, 1'b0);
			check(stat_o.evt_count, 0);
			ext_i = ~ext_i;
			tick(30);
			check(stat_o.gate_open, 1'b1);
			check(stat_o.evt_count != 0, 1'b1);
			ext_i = ~ext_i;
			tick(10);
			n = stat_o.evt_count;
			tick(40);
			check(stat_o.evt_count, n);
			wait_done(MAXC + 300);
			check(stat_o.end_cause, END_MAXTIME);
		end
		// External arming: no delay, time delay, five-event delay
		for (i = 0; i < 3; i++) begin
			c = '0;
			c.evt_limit = 27'h000_0002;
			c.arm_ext = 1'b1;
			c.arm_fall = (i == 1);
			c.dly = mgac_dly_t'(i);
			c.dly_us = 20'h0_0002;
			c.dly_code = 6'h04;
			ext_i = c.arm_fall;
			tick(8);
			go(c);
			tick(40);
			check(stat_o.armed, 1'b0);
			check(stat_o.evt_count, 0);
			ext_i = ~ext_i;
			wait_done(400);
			check(dur >= lo[i] && dur <= hi[i], 1'b1);
			check(stat_o.evt_count, 2);
		end
		// Inhibit off, active high, active low
		for (i = 0; i < 3; i++) begin
			c = '0;
			c.evt_limit = 27'h000_0003;
			c.inh = mgac_inh_t'(i);
			inh_i = (i != 2);
			tick(8);
			go(c);
			tick(60);
			check(stat_o.evt_count, (i == 0) ? 3 : 0);
			if (i != 0) begin
				check(stat_o.gate_open, 1'b0);
				inh_i = ~inh_i;
				wait_done(100);
				check(stat_o.evt_count, 3);
			end
		end
		// Reset while waiting for an arm edge
		c = '0;
		c.arm_ext = 1'b1;
		go(c);
		tick(5);
		rst_i = 1'b1;
		tick(3);
		check({stat_o, block_done_o, sample_tick_o} === 35'h0, 1'b1);
		rst_i = 1'b0;
		// Arm pin idles high: the flush after reset must not arm
		go(c);
		tick(20);
		check(stat_o.active, 1'b1);
		check(stat_o.armed, 1'b0);
		end_sim();
	end
endmodule : mgac_gate_arm_ctrl_test
`default_nettype wire

// ===== tb/mgac_pin_model.sv
// Event sources on the two measured channels
`timescale 1ns/1ps
`default_nettype none

module mgac_pin_model (
	input wire logic clk_sys_i,
	input wire logic ena_a_i,
	input wire logic ena_b_i,
	output logic chan_a_o,
	output logic chan_b_o
);
	logic [1:0] phase = 2'h0; // Free-running event phase

	// ----------------------------------------
	// Event trains
	// ----------------------------------------
	// Two high, two low: widest legal rate, edges 4 cycles apart
	always_ff @(posedge clk_sys_i) begin
		phase <= phase + 2'h1;
	end
	assign chan_a_o = ena_a_i & phase[1];
	assign chan_b_o = ena_b_i & phase[1];
endmodule : mgac_pin_model
`default_nettype wire
